// ---- logic/readout_pkg.sv ----
// constants shared by both ends of the measurement read-out link
package readout_pkg;

   // ***********************************************************
   // command codes and data widths
   // ***********************************************************
   localparam int        CMD_W                = 8;
   localparam int        DATA_W               = 8;
   localparam int        CNT_W                = 16;
   localparam int        BIT_CNT_W            = 5;
   localparam logic [7:0] CMD_WRITE_SETTINGS  = 8'h51;
   localparam logic [7:0] CMD_READ_SETTINGS   = 8'h52;
   localparam logic [7:0] CMD_START_MEASURE   = 8'h53;
   localparam logic [7:0] CMD_FETCH_RESULTS   = 8'h54;

   // ***********************************************************
   // frame bit positions (rising sclk edge index)
   // ***********************************************************
   localparam logic [4:0] CMD_LAST_BIT        = 5'h07;
   localparam logic [4:0] DATA_LAST_BIT       = 5'h0f;
   localparam logic [4:0] BIT_CNT_MAX         = 5'h1f;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [7:0] SETTINGS_RESET      = 8'h00;
   localparam logic [7:0] RESULT_CLEAR        = 8'h00;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int REF_CLK_NS    = 40;
   localparam int T_STARTUP_NS  = 2000;
   localparam int T_MEASURE_NS  = 4000;
   localparam int STARTUP_CYC   =
      (T_STARTUP_NS + REF_CLK_NS - 1) / REF_CLK_NS;
   localparam int MEASURE_CYC   =
      (T_MEASURE_NS + REF_CLK_NS - 1) / REF_CLK_NS;
   localparam int SCLK_HALF_CYC = 2;
   localparam int FRAME_GAP_CYC = 8;

endpackage : readout_pkg

// ---- logic/readout_link_if.sv ----
// serial link between the sensor end and the host end
`timescale 1ns/1ps
interface readout_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso_out;
   logic miso_oe_n;
   logic miso;
   logic result_ready_line;

   // released line reads low
   assign miso = miso_oe_n ? 1'b0 : miso_out;

   modport device (
      input  sclk,
      input  cs_n,
      input  mosi,
      output miso_out,
      output miso_oe_n,
      output result_ready_line
   );

   modport host (
      output sclk,
      output cs_n,
      output mosi,
      input  miso,
      input  result_ready_line
   );
endinterface : readout_link_if

// ---- logic/readout_device.sv ----
// sensor end: command decode, measurement sequencing, result read-out
//
// Behaviour
// [RULE1] reset phase before any command accepted
// [RULE2] ready line high once first command allowed
// [RULE3] start command begins measurement cycle
// [RULE4] ready line high when measurement finished
// [RULE5] fetch command shifts results out
// [RULE6] host starts measuring only after read-out
// [RULE7] write command stores new settings
// [RULE8] read command returns current settings
// [RULE9] start with extra clocks is combined transfer
// [RULE10] extra clocks shift stored results out
// [RULE11] combined measurement starts on chip select rise
// [RULE12] ready low for start-up, then high
// [RULE13] data out released while chip select high
// [RULE14] read-out end clears results to zero
// [RULE15] ready low from start until measurement done
`timescale 1ns/1ps
module readout_device #(
   parameter int STARTUP_CYC = readout_pkg::STARTUP_CYC,
   parameter int MEASURE_CYC = readout_pkg::MEASURE_CYC
) (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   readout_link_if.device                     link,
   input  wire logic [readout_pkg::DATA_W-1:0] meas_value,
   output logic      [readout_pkg::DATA_W-1:0] settings,
   output logic                               measuring
);

   typedef enum logic [1:0] {
      ST_STARTUP,
      ST_IDLE,
      ST_MEASURE,
      ST_DONE
   } seq_state_e;

   localparam logic [readout_pkg::CNT_W-1:0] STARTUP_LAST =
      readout_pkg::CNT_W'(STARTUP_CYC - 1);
   localparam logic [readout_pkg::CNT_W-1:0] MEASURE_LAST =
      readout_pkg::CNT_W'(MEASURE_CYC - 1);

   // ***********************************************************
   // link clock domain
   // ***********************************************************
   logic                                 frame_rst;
   logic [readout_pkg::BIT_CNT_W-1:0]    bit_cnt_r;
   logic [7:0]                           shift_r;
   logic [7:0]                           rx_byte;
   logic [7:0]                           cmd_hold_r;
   logic [7:0]                           data_hold_r;
   logic                                 long_r;
   logic                                 cmd_tgl_r;
   logic [7:0]                           tx_r;

   // ref domain registers read quasi-statically by the link side
   logic [readout_pkg::DATA_W-1:0]       settings_r;
   logic [readout_pkg::DATA_W-1:0]       result_r;

   assign frame_rst = rst | link.cs_n;
   assign rx_byte   = {shift_r[6:0], link.mosi};

   // bit position within the current frame
   always_ff @(posedge link.sclk or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_r <= '0;
      end else if (bit_cnt_r != readout_pkg::BIT_CNT_MAX) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge link.sclk or posedge rst) begin
      if (rst) begin
         shift_r <= 8'h00;
      end else begin
         shift_r <= rx_byte;
      end
   end

   // command byte and optional second byte, held after frame end
   always_ff @(posedge link.sclk or posedge rst) begin
      if (rst) begin
         cmd_hold_r  <= 8'h00;
         data_hold_r <= 8'h00;
         long_r      <= 1'b0;
         cmd_tgl_r   <= 1'b0;
      end else if (bit_cnt_r == readout_pkg::CMD_LAST_BIT) begin
         cmd_hold_r <= rx_byte;
         long_r     <= 1'b0;
         cmd_tgl_r  <= ~cmd_tgl_r;
      end else if (bit_cnt_r == readout_pkg::DATA_LAST_BIT) begin
         // [RULE9] extra clocks seen
         data_hold_r <= rx_byte;
         long_r      <= 1'b1;
      end
   end

   // response byte, msb first after the command byte
   always_ff @(posedge link.sclk or posedge rst) begin
      if (rst) begin
         tx_r <= 8'h00;
      end else if (bit_cnt_r == readout_pkg::CMD_LAST_BIT) begin
         // [RULE8] settings read back
         if (rx_byte == readout_pkg::CMD_READ_SETTINGS) begin
            tx_r <= settings_r;
         end else begin
            // [RULE5] [RULE10] results shifted out
            tx_r <= result_r;
         end
      end else begin
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end

   assign link.miso_out  = tx_r[7];
   // [RULE13] released while deselected
   assign link.miso_oe_n = link.cs_n;

   // ***********************************************************
   // crossing into the reference clock domain
   // ***********************************************************
   logic cs_m_r;
   logic cs_s_r;
   logic cs_d_r;
   logic tgl_m_r;
   logic tgl_s_r;
   logic tgl_seen_r;
   logic frame_end;
   logic new_cmd;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cs_m_r  <= 1'b1;
         cs_s_r  <= 1'b1;
         cs_d_r  <= 1'b1;
         tgl_m_r <= 1'b0;
         tgl_s_r <= 1'b0;
      end else begin
         cs_m_r  <= link.cs_n;
         cs_s_r  <= cs_m_r;
         cs_d_r  <= cs_s_r;
         tgl_m_r <= cmd_tgl_r;
         tgl_s_r <= tgl_m_r;
      end
   end

   assign frame_end = cs_s_r & ~cs_d_r;
   assign new_cmd   = frame_end & (tgl_s_r != tgl_seen_r);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tgl_seen_r <= 1'b0;
      end else if (frame_end) begin
         tgl_seen_r <= tgl_s_r;
      end
   end

   // ***********************************************************
   // measurement sequencer
   // ***********************************************************
   seq_state_e                       state_r;
   seq_state_e                       state_nxt;
   logic [readout_pkg::CNT_W-1:0]    cnt_r;
   logic                             is_start;
   logic                             is_fetch;
   logic                             is_write;
   logic                             readout_end;
   logic                             meas_end;
   logic                             ready_r;

   assign is_start = new_cmd &
      (cmd_hold_r == readout_pkg::CMD_START_MEASURE);
   assign is_fetch = new_cmd &
      (cmd_hold_r == readout_pkg::CMD_FETCH_RESULTS);
   assign is_write = new_cmd & long_r &
      (cmd_hold_r == readout_pkg::CMD_WRITE_SETTINGS);
   assign meas_end = (state_r == ST_MEASURE) & (cnt_r == MEASURE_LAST);
   // [RULE14] plain fetch or combined start ends a read-out
   assign readout_end = (state_r == ST_DONE) &
      (is_fetch | (is_start & long_r));

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_STARTUP: begin
            // [RULE1] commands ignored until start-up ends
            if (cnt_r == STARTUP_LAST) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // [RULE3] [RULE11] start on chip select rise
            if (is_start) begin
               state_nxt = ST_MEASURE;
            end
         end
         ST_MEASURE: begin
            if (meas_end) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            // [RULE9] combined transfer restarts measuring
            if (is_start) begin
               state_nxt = ST_MEASURE;
            end else if (is_fetch) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_STARTUP;
      end else begin
         state_r <= state_nxt;
      end
   end

   // start-up and measurement timer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (state_nxt != state_r) begin
         cnt_r <= '0;
      end else if (state_r == ST_STARTUP || state_r == ST_MEASURE) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // [RULE2] [RULE4] [RULE12] [RULE15] ready follows sequencer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= (state_nxt == ST_IDLE) || (state_nxt == ST_DONE);
      end
   end

   assign link.result_ready_line = ready_r;

   // ***********************************************************
   // result and settings storage
   // ***********************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         result_r <= readout_pkg::RESULT_CLEAR;
      end else if (meas_end) begin
         result_r <= meas_value;
      end else if (readout_end) begin
         // [RULE14] clear after read-out
         result_r <= readout_pkg::RESULT_CLEAR;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         settings_r <= readout_pkg::SETTINGS_RESET;
      end else if (is_write && (state_r == ST_IDLE ||
                                state_r == ST_DONE)) begin
         // [RULE7] store between cycles
         settings_r <= data_hold_r;
      end
   end

   assign settings  = settings_r;
   assign measuring = (state_r == ST_MEASURE);

endmodule : readout_device

// ---- logic/readout_host.sv ----
// host end: frames commands on the link and returns response bytes
`timescale 1ns/1ps
module readout_host #(
   parameter int SCLK_HALF_CYC = readout_pkg::SCLK_HALF_CYC,
   parameter int FRAME_GAP_CYC = readout_pkg::FRAME_GAP_CYC
) (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   readout_link_if.host                       link,
   input  wire logic                          req_valid,
   input  wire logic [7:0]                    req_cmd,
   input  wire logic [7:0]                    req_data,
   input  wire logic                          req_long,
   output logic                               req_ready,
   output logic                               rsp_valid,
   output logic [7:0]                         rsp_data,
   output logic                               dev_ready
);

   typedef enum logic [2:0] {
      H_IDLE,
      H_LEAD,
      H_SHIFT,
      H_TRAIL,
      H_GAP
   } host_state_e;

   localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
   localparam logic [7:0] GAP_LAST  = 8'(FRAME_GAP_CYC - 1);

   // ***********************************************************
   // pin synchronisers
   // ***********************************************************
   logic miso_m_r;
   logic miso_s_r;
   logic rdy_m_r;
   logic rdy_s_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         miso_m_r <= 1'b0;
         miso_s_r <= 1'b0;
         rdy_m_r  <= 1'b0;
         rdy_s_r  <= 1'b0;
      end else begin
         miso_m_r <= link.miso;
         miso_s_r <= miso_m_r;
         rdy_m_r  <= link.result_ready_line;
         rdy_s_r  <= rdy_m_r;
      end
   end

   assign dev_ready = rdy_s_r;

   // ***********************************************************
   // frame sequencer and clock divider
   // ***********************************************************
   host_state_e  state_r;
   logic [7:0]   div_r;
   logic [15:0]  frame_r;
   logic [4:0]   bit_idx_r;
   logic [4:0]   last_bit_r;
   logic         sclk_r;
   logic         cs_n_r;
   logic         long_r;
   logic [7:0]   rx_r;
   logic         rsp_valid_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r     <= H_IDLE;
         div_r       <= 8'h00;
         frame_r     <= 16'h0000;
         bit_idx_r   <= 5'h00;
         last_bit_r  <= 5'h00;
         sclk_r      <= 1'b0;
         cs_n_r      <= 1'b1;
         long_r      <= 1'b0;
         rx_r        <= 8'h00;
         rsp_valid_r <= 1'b0;
      end else begin
         rsp_valid_r <= 1'b0;
         div_r       <= div_r + 8'h01;
         unique case (state_r)
            H_IDLE: begin
               div_r <= 8'h00;
               if (req_valid) begin
                  // [RULE3] [RULE5] [RULE7] [RULE8] command upload
                  frame_r    <= {req_cmd, req_data};
                  // [RULE9] extra clocks on request
                  long_r     <= req_long;
                  last_bit_r <= req_long ? readout_pkg::DATA_LAST_BIT :
                                           readout_pkg::CMD_LAST_BIT;
                  bit_idx_r  <= 5'h00;
                  cs_n_r     <= 1'b0;
                  state_r    <= H_LEAD;
               end
            end
            H_LEAD: begin
               if (div_r == HALF_LAST) begin
                  div_r   <= 8'h00;
                  state_r <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (div_r == HALF_LAST) begin
                  div_r  <= 8'h00;
                  sclk_r <= ~sclk_r;
                  if (!sclk_r) begin
                     rx_r <= {rx_r[6:0], miso_s_r};
                  end else if (bit_idx_r == last_bit_r) begin
                     state_r <= H_TRAIL;
                  end else begin
                     bit_idx_r <= bit_idx_r + 5'h01;
                     frame_r   <= {frame_r[14:0], 1'b0};
                  end
               end
            end
            H_TRAIL: begin
               if (div_r == HALF_LAST) begin
                  div_r       <= 8'h00;
                  cs_n_r      <= 1'b1;
                  rsp_valid_r <= long_r;
                  state_r     <= H_GAP;
               end
            end
            H_GAP: begin
               if (div_r == GAP_LAST) begin
                  state_r <= H_IDLE;
               end
            end
            default: begin
               state_r <= H_IDLE;
            end
         endcase
      end
   end

   assign link.sclk = sclk_r;
   assign link.cs_n = cs_n_r;
   assign link.mosi = frame_r[15];
   assign req_ready = (state_r == H_IDLE);
   assign rsp_valid = rsp_valid_r;
   assign rsp_data  = rx_r;

endmodule : readout_host

// ---- testbench/readout_link_sva.sv ----
// concurrent checks on the readout link wires
`timescale 1ns/1ps
module readout_link_sva #(
   parameter int STARTUP_CYC = readout_pkg::STARTUP_CYC,
   parameter int MEASURE_CYC = readout_pkg::MEASURE_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso_out,
   input wire logic miso_oe_n,
   input wire logic miso,
   input wire logic result_ready_line
);
   localparam int MEAS_HI = MEASURE_CYC + 4;
   logic [15:0] up_cnt;
   logic        sclk_q;
   logic        cs_q;
   logic        cleared;
   logic [4:0]  nbits;
   logic [7:0]  cmd_sh;
   logic [7:0]  rsp_sh;
   wire         sclk_rise = sclk & ~sclk_q;
   wire         sclk_fall = ~sclk & sclk_q;
   wire         frame_end = cs_n & ~cs_q;
   // ***********************************************************
   // frame decode in the reference clock domain
   // ***********************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) up_cnt <= 16'h0000;
      else if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h0001;
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
      end else begin
         sclk_q <= sclk;
         cs_q   <= cs_n;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) nbits <= 5'h00;
      else if (cs_n) nbits <= 5'h00;
      else if (sclk_rise && nbits != 5'h1f) nbits <= nbits + 5'h01;
   end
   // mosi steady at rise, miso steady at fall
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_sh <= 8'h00;
         rsp_sh <= 8'h00;
      end else if (!cs_n) begin
         if (sclk_rise && nbits < 5'h08) cmd_sh <= {cmd_sh[6:0], mosi};
         if (sclk_fall && nbits >= 5'h08 && nbits < 5'h10)
            rsp_sh <= {rsp_sh[6:0], miso};
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) cleared <= 1'b0;
      else if ($rose(result_ready_line)) cleared <= 1'b0;
      else if (frame_end && nbits == 5'h10 &&
               (cmd_sh == readout_pkg::CMD_START_MEASURE ||
                cmd_sh == readout_pkg::CMD_FETCH_RESULTS)) cleared <= 1'b1;
   end
   // ***********************************************************
   // properties
   // ***********************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_startup_low;
      (up_cnt < STARTUP_CYC - 1) |-> !result_ready_line;
   endproperty
   a_startup_low: assert property (p_startup_low)
      else $error("ready line high during start-up");
   property p_ready_up;
      (up_cnt == STARTUP_CYC + 4) |-> result_ready_line;
   endproperty
   a_ready_up: assert property (p_ready_up)
      else $error("ready line not high after start-up");
   property p_oe_cs;
      miso_oe_n == cs_n;
   endproperty
   a_oe_cs: assert property (p_oe_cs)
      else $error("data out enable differs from chip select");
   property p_fall_idle;
      $fell(result_ready_line) |-> cs_n && $past(cs_n, 2);
   endproperty
   a_fall_idle: assert property (p_fall_idle)
      else $error("ready line fell inside a frame");
   property p_start_drop;
      (frame_end && cmd_sh == readout_pkg::CMD_START_MEASURE &&
       nbits >= 5'h08 && result_ready_line &&
       up_cnt > STARTUP_CYC + 4) |-> ##[1:6] !result_ready_line;
   endproperty
   a_start_drop: assert property (p_start_drop)
      else $error("start frame did not drop ready line");
   property p_hold_low;
      $fell(result_ready_line) |-> !result_ready_line [*8];
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("ready line rose too early");
   property p_meas_done;
      $fell(result_ready_line) |-> ##[1:MEAS_HI] result_ready_line;
   endproperty
   a_meas_done: assert property (p_meas_done)
      else $error("measurement did not finish in time");
   property p_clear;
      (frame_end && nbits == 5'h10 && cleared &&
       cmd_sh != readout_pkg::CMD_READ_SETTINGS) |->
         rsp_sh == readout_pkg::RESULT_CLEAR;
   endproperty
   a_clear: assert property (p_clear)
      else $error("results not cleared after read-out");
endmodule : readout_link_sva

// ---- testbench/tb.sv ----
// self-checking bench joining both link ends
`timescale 1ns/1ps
module tb;
   localparam int STARTUP = 100;
   localparam int MEASURE = 20;
   logic       ref_clk    = 1'b0;
   logic       rst        = 1'b1;
   logic       req_valid  = 1'b0;
   logic [7:0] req_cmd    = 8'h00;
   logic [7:0] req_data   = 8'h00;
   logic       req_long   = 1'b0;
   logic [7:0] meas_value = 8'h00;
   logic [7:0] settings;
   logic       measuring;
   logic       req_ready;
   logic       rsp_valid;
   logic [7:0] rsp_data;
   logic       dev_ready;
   logic [7:0] rsp;
   logic       mse;
   int         n_mismatch = 0;
   int         cmp_count  = 0;
   // ***********************************************************
   // ends, link and checker
   // ***********************************************************
   readout_link_if link ();
   readout_device #(.STARTUP_CYC(STARTUP), .MEASURE_CYC(MEASURE))
      readout_device_i (.ref_clk, .rst, .link(link.device), .meas_value,
                        .settings, .measuring);
   readout_host readout_host_i (.ref_clk, .rst, .link(link.host),
      .req_valid, .req_cmd, .req_data, .req_long, .req_ready, .rsp_valid,
      .rsp_data, .dev_ready);
   readout_link_sva #(.STARTUP_CYC(STARTUP), .MEASURE_CYC(MEASURE))
      readout_link_sva_i (.ref_clk, .rst, .sclk(link.sclk),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso_out(link.miso_out),
      .miso_oe_n(link.miso_oe_n), .miso(link.miso),
      .result_ready_line(link.result_ready_line));
   always #20 ref_clk = ~ref_clk;
   // ***********************************************************
   // shared tasks
   // ***********************************************************
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one host frame; response and measuring sampled at frame end of a long frame only
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] data,
                       input logic lng);
      int   i;
      logic busy;
      busy = 1'b0;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_cmd   <= cmd;
      req_data  <= data;
      req_long  <= lng;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      for (i = 0; i < 300; i++) begin
         @(negedge ref_clk);
         if (rsp_valid === 1'b1) begin
            rsp = rsp_data;
            mse = measuring;
         end
         if (req_ready === 1'b0) busy = 1'b1;
         else if (busy) break;
      end
      if (i == 300) check("frame done", 8'h00, 8'h01);
   endtask : xfer
   task automatic wait_ready(input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(negedge ref_clk);
         if (link.result_ready_line === 1'b1) break;
      end
      check("ready line", link.result_ready_line, 8'h01);
      repeat (2) @(negedge ref_clk);
      check("host ready copy", dev_ready, 8'h01);
   endtask : wait_ready
   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_startup;
      xfer(readout_pkg::CMD_WRITE_SETTINGS, 8'h5a, 1'b1);
      check("settings in start-up", settings, 8'h00);
      check("ready in start-up", link.result_ready_line, 8'h00);
      check("host ready in start-up", dev_ready, 8'h00);
      check("released data out", link.miso_oe_n, 8'h01);
      wait_ready(80);
   endtask : t_startup
   task automatic t_settings;
      xfer(readout_pkg::CMD_WRITE_SETTINGS, 8'ha5, 1'b1);
      check("settings written", settings, 8'ha5);
      xfer(readout_pkg::CMD_WRITE_SETTINGS, 8'h3c, 1'b0);
      check("short write refused", settings, 8'ha5);
      xfer(readout_pkg::CMD_READ_SETTINGS, 8'h00, 1'b1);
      check("settings read back", rsp, 8'ha5);
   endtask : t_settings
   task automatic t_plain;
      @(posedge ref_clk);
      meas_value <= 8'h3c;
      xfer(readout_pkg::CMD_START_MEASURE, 8'h00, 1'b0);
      check("measuring after start", measuring, 8'h01);
      check("ready low measuring", link.result_ready_line, 8'h00);
      check("host ready low", dev_ready, 8'h00);
      wait_ready(60);
      check("measuring done", measuring, 8'h00);
      xfer(readout_pkg::CMD_FETCH_RESULTS, 8'h00, 1'b1);
      check("fetched result", rsp, 8'h3c);
   endtask : t_plain
   task automatic t_combined;
      xfer(readout_pkg::CMD_START_MEASURE, 8'h00, 1'b1);
      check("cleared result", rsp, 8'h00);
      check("no start in frame", mse, 8'h00);
      check("combined started", measuring, 8'h01);
      @(posedge ref_clk);
      meas_value <= 8'h96;
      wait_ready(60);
      xfer(readout_pkg::CMD_START_MEASURE, 8'hff, 1'b1);
      check("combined result", rsp, 8'h96);
      wait_ready(60);
      xfer(readout_pkg::CMD_FETCH_RESULTS, 8'h00, 1'b1);
      check("fetch after combined", rsp, 8'h96);
      xfer(readout_pkg::CMD_READ_SETTINGS, 8'h00, 1'b1);
      check("settings kept", rsp, 8'ha5);
   endtask : t_combined
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_startup();
      t_settings();
      t_plain();
      t_combined();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      wrap_up();
   end
endmodule : tb
